// file: rtl/osc_pkg.sv
// Package for the output stage configuration register bank.
// Assumes an 8-bit paged register port and a 25 MHz control clock.
package osc_pkg;

  // Page select lives at the same address on every page
  localparam logic [7:0] PAGE_SEL_ADDR  = 8'h00;
  localparam logic [7:0] PAGE_SEL_RST   = 8'h00;
  localparam logic [7:0] CFG_PAGE       = 8'h01;

  // Register offsets on the configuration page
  localparam logic [7:0] CM_CTRL_ADDR   = 8'h0a;
  localparam logic [7:0] OCP_CFG_ADDR   = 8'h0b;
  localparam logic [7:0] LHP_ROUTE_ADDR = 8'h0c;

  // Writable bits; reserved bits outside the masks stay zero
  localparam logic [7:0] CM_CTRL_MASK   = 8'h7b;
  localparam logic [7:0] OCP_CFG_MASK   = 8'h1f;
  localparam logic [7:0] LHP_ROUTE_MASK = 8'h0f;

  // Reset values
  localparam logic [7:0] CM_CTRL_RST    = 8'h00;
  localparam logic [7:0] OCP_CFG_RST    = 8'h10;
  localparam logic [7:0] LHP_ROUTE_RST  = 8'h00;

  // Field positions, common mode register
  localparam int CM_FULL_BIT  = 6;
  localparam int HP_CM_LSB    = 4;
  localparam int LO_CM_BIT    = 3;
  localparam int HP_SUP_BIT   = 1;
  localparam int REGIN_RNG_BIT = 0;

  // Field positions, protection register
  localparam int OC_EN_BIT    = 4;
  localparam int DEB_LSB      = 1;
  localparam int OC_ACT_BIT   = 0;

  // Field positions, left headphone routing register
  localparam int RT_DAC_BIT   = 3;
  localparam int RT_IN1_BIT   = 2;
  localparam int RT_LMIX_BIT  = 1;
  localparam int RT_RMIX_BIT  = 0;

  // Debounce timing: code n above zero waits base * 2^(n-1), code 0 waits none
  localparam int CLK_HZ       = 25_000_000;
  localparam int DEB_BASE_MS  = 8;
  localparam int DEB_BASE_CYC = CLK_HZ / 1000 * DEB_BASE_MS;

  // Routing enables of the left headphone driver
  typedef struct packed {
    logic dac_pos;
    logic left_input_one;
    logic left_mixer_amp;
    logic right_mixer_amp;
  } osc_route_t;

  // Decoded configuration handed to the analog side
  typedef struct packed {
    logic       cm_low;
    logic [1:0] hp_cm_sel;
    logic       lo_cm_fixed;
    logic       hp_sup_regin;
    logic       regin_wide;
    osc_route_t route;
  } osc_cfg_t;

endpackage

// file: rtl/osc_regs.sv
// Output stage configuration registers with over-current debounce.
// Assumes one synchronous clock, bus strobes aligned to it and
// raw over-current flags already synchronous to the clock.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ns

module osc_regs #(
  parameter int NUM_DRV  = 2,
  parameter int CNT_W    = 24,
  parameter int DEB_BASE = osc_pkg::DEB_BASE_CYC
) (
  input  wire logic               sys_clk_in,
  input  wire logic               sys_rst_in,
  input  wire logic [7:0]         reg_addr_in,
  input  wire logic [7:0]         reg_wdata_in,
  input  wire logic               reg_wr_in,
  input  wire logic               reg_rd_in,
  output logic      [7:0]         reg_rdata_out,
  input  wire logic [NUM_DRV-1:0] oc_raw_in,
  output osc_pkg::osc_cfg_t       cfg_out,
  output logic      [NUM_DRV-1:0] oc_limit_out,
  output logic      [NUM_DRV-1:0] oc_pdn_out
);

  logic [7:0] page_reg;
  logic [7:0] cm_reg;
  logic [7:0] ocp_reg;
  logic [7:0] route_reg;
  logic [7:0] rdata_next;

  // One clock domain, so every assertion below shares this clock and reset
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  // Address decode
  wire on_cfg_page = (page_reg == osc_pkg::CFG_PAGE);
  wire hit_page    = (reg_addr_in == osc_pkg::PAGE_SEL_ADDR);
  wire hit_cm      = on_cfg_page && (reg_addr_in == osc_pkg::CM_CTRL_ADDR);
  wire hit_ocp     = on_cfg_page && (reg_addr_in == osc_pkg::OCP_CFG_ADDR);
  wire hit_route   = on_cfg_page && (reg_addr_in == osc_pkg::LHP_ROUTE_ADDR);

  // Masked write data; reserved positions never store a one
  wire [7:0] cm_wval    = reg_wdata_in & osc_pkg::CM_CTRL_MASK;
  wire [7:0] ocp_wval   = reg_wdata_in & osc_pkg::OCP_CFG_MASK;
  wire [7:0] route_wval = reg_wdata_in & osc_pkg::LHP_ROUTE_MASK;

  // Read mux, unmapped offsets answer zero
  always_comb begin
    rdata_next = 8'h00;
    if (hit_page) begin
      rdata_next = page_reg;
    end else if (hit_cm) begin
      rdata_next = cm_reg;
    end else if (hit_ocp) begin
      rdata_next = ocp_reg;
    end else if (hit_route) begin
      rdata_next = route_reg;
    end
  end

  // Register writes
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      page_reg  <= osc_pkg::PAGE_SEL_RST;
      cm_reg    <= osc_pkg::CM_CTRL_RST;
      ocp_reg   <= osc_pkg::OCP_CFG_RST;
      route_reg <= osc_pkg::LHP_ROUTE_RST;
    end else if (reg_wr_in) begin
      if (hit_page)  page_reg  <= reg_wdata_in;
      if (hit_cm)    cm_reg    <= cm_wval;
      if (hit_ocp)   ocp_reg   <= ocp_wval;
      if (hit_route) route_reg <= route_wval;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 8'h00;
    end else begin
      reg_rdata_out <= reg_rd_in ? rdata_next : 8'h00;
    end
  end

  // Decoded configuration fields
  osc_pkg::osc_cfg_t cfg_next;
  assign cfg_next.cm_low       = cm_reg[osc_pkg::CM_FULL_BIT];
  assign cfg_next.hp_cm_sel    = cm_reg[osc_pkg::HP_CM_LSB +: 2];
  assign cfg_next.lo_cm_fixed  = cm_reg[osc_pkg::LO_CM_BIT];
  assign cfg_next.hp_sup_regin = cm_reg[osc_pkg::HP_SUP_BIT];
  // Range only matters on the regulator supply, so it is masked off otherwise
  assign cfg_next.regin_wide   = cm_reg[osc_pkg::REGIN_RNG_BIT]
                                 & cm_reg[osc_pkg::HP_SUP_BIT];
  assign cfg_next.route.dac_pos         = route_reg[osc_pkg::RT_DAC_BIT];
  assign cfg_next.route.left_input_one  = route_reg[osc_pkg::RT_IN1_BIT];
  assign cfg_next.route.left_mixer_amp  = route_reg[osc_pkg::RT_LMIX_BIT];
  assign cfg_next.route.right_mixer_amp = route_reg[osc_pkg::RT_RMIX_BIT];

  // Registered so the analog side sees glitch-free levels
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cfg_out <= '0;
    end else begin
      cfg_out <= cfg_next;
    end
  end

  // Protection controls
  wire       oc_en    = ocp_reg[osc_pkg::OC_EN_BIT];
  wire [2:0] deb_code = ocp_reg[osc_pkg::DEB_LSB +: 3];
  wire       pdn_mode = ocp_reg[osc_pkg::OC_ACT_BIT];

  // Debounce length in cycles; widest code needs CNT_W bits
  wire [CNT_W-1:0] deb_tgt = (deb_code == 3'b000) ? '0 :
                             (CNT_W'(DEB_BASE) << (deb_code - 3'd1));

  logic [CNT_W-1:0] cnt_q [NUM_DRV];

  // One debounce counter per headphone driver
  for (genvar g = 0; g < NUM_DRV; g++) begin : g_drv
    wire             active   = oc_en && oc_raw_in[g];
    wire             reached  = active && (cnt_q[g] >= deb_tgt);
    wire [CNT_W-1:0] cnt_next = !active ? '0 :
                                (cnt_q[g] < deb_tgt) ? cnt_q[g] + CNT_W'(1) : cnt_q[g];

    // Counter saturates at the target instead of wrapping
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        cnt_q[g] <= '0;
      end else begin
        cnt_q[g] <= cnt_next;
      end
    end

    // Response follows the mode bit at every cycle of the fault
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        oc_limit_out[g] <= 1'b0;
        oc_pdn_out[g]   <= 1'b0;
      end else begin
        oc_limit_out[g] <= reached && !pdn_mode;
        oc_pdn_out[g]   <= reached && pdn_mode;
      end
    end

    // Raw flag dropping clears the count and the response
    drop_restart_a: assert property (
      !oc_raw_in[g] |=> (cnt_q[g] == '0) && !oc_limit_out[g] && !oc_pdn_out[g])
      else $error("debounce not restarted on drop");

    // No response while count has not reached the target
    deb_hold_a: assert property (
      (cnt_q[g] < deb_tgt) |=> !oc_limit_out[g] && !oc_pdn_out[g])
      else $error("response before debounce elapsed");

    // Code 000 responds on the next edge
    no_deb_a: assert property (
      oc_en && (deb_code == 3'b000) && oc_raw_in[g]
      |=> (oc_limit_out[g] ^ oc_pdn_out[g]))
      else $error("undebounced fault not acted on");

    // Detection off means no response at all
    oc_off_a: assert property (
      !oc_en |=> !oc_limit_out[g] && !oc_pdn_out[g])
      else $error("response while detection disabled");

    // Response kind matches the mode bit
    act_sel_a: assert property (
      oc_pdn_out[g] |-> $past(pdn_mode) && !oc_limit_out[g])
      else $error("power-down without power-down mode");

    // Current limiting only in limiting mode
    limit_sel_a: assert property (
      oc_limit_out[g] |-> !$past(pdn_mode) && !oc_pdn_out[g])
      else $error("current limit in power-down mode");

    // A response needs an enabled, standing fault one edge earlier
    needs_raw_a: assert property (
      (oc_limit_out[g] || oc_pdn_out[g]) |-> $past(oc_raw_in[g]) && $past(oc_en))
      else $error("response without a standing fault");
  end

  // Write on the config page then the full-chip level on cfg_out two edges later
  sequence cm_write_s;
    reg_wr_in && hit_cm;
  endsequence

  sequence cm_follow_s;
    ##1 (cfg_out.cm_low == $past(reg_wdata_in[osc_pkg::CM_FULL_BIT], 2));
  endsequence

  cm_follow_a: assert property (
    cm_write_s |=> cm_follow_s)
    else $error("full-chip level did not follow write");

  // Reset raised between two samples leaves the past value stale, so that edge is skipped
  hp_cm_a: assert property (
    !sys_rst_in |-> cfg_out.hp_cm_sel == $past(cm_reg[osc_pkg::HP_CM_LSB +: 2]))
    else $error("headphone common mode mismatch");

  lo_cm_a: assert property (
    !sys_rst_in |-> cfg_out.lo_cm_fixed == $past(cm_reg[osc_pkg::LO_CM_BIT]))
    else $error("line common mode mismatch");

  range_gate_a: assert property (
    cfg_out.regin_wide |-> cfg_out.hp_sup_regin)
    else $error("wide range without regulator supply");

  route_out_a: assert property (
    !sys_rst_in |-> cfg_out.route == $past(route_reg[3:0]))
    else $error("routing enables mismatch");

  // Reserved bit 7 reads zero on every mapped config register
  reserved_zero_a: assert property (
    reg_rd_in && !hit_page |=> reg_rdata_out[7] == 1'b0)
    else $error("reserved bit read as one");

  // Read of the protection register returns its stored value
  ocp_read_a: assert property (
    reg_rd_in && on_cfg_page && (reg_addr_in == osc_pkg::OCP_CFG_ADDR)
    |=> reg_rdata_out == $past(ocp_reg))
    else $error("protection register read wrong");

  // Off-page writes leave the config registers alone
  page_gate_a: assert property (
    reg_wr_in && !on_cfg_page |=> $stable(cm_reg) && $stable(ocp_reg) && $stable(route_reg))
    else $error("config register written off page");

  // Read data is one cycle only
  rd_once_a: assert property (
    !reg_rd_in |=> reg_rdata_out == 8'h00)
    else $error("read data outside its cycle");

  // Reset values come back on every release, whatever was stored before
  rst_vals_a: assert property (
    $fell(sys_rst_in) |-> (ocp_reg == osc_pkg::OCP_CFG_RST) && (cm_reg == osc_pkg::CM_CTRL_RST)
                          && (route_reg == osc_pkg::LHP_ROUTE_RST) && (page_reg == osc_pkg::PAGE_SEL_RST))
    else $error("register not at reset value after release");

  hp_sup_a: assert property (
    !sys_rst_in |-> cfg_out.hp_sup_regin == $past(cm_reg[osc_pkg::HP_SUP_BIT]))
    else $error("headphone supply select mismatch");

  // A write lands with its reserved positions cleared
  cm_write_a: assert property (
    cm_write_s |=> cm_reg == ($past(reg_wdata_in) & osc_pkg::CM_CTRL_MASK))
    else $error("common mode register write lost");

  // Protection write on the config page
  sequence ocp_write_s;
    reg_wr_in && hit_ocp;
  endsequence

  ocp_write_a: assert property (
    ocp_write_s |=> ocp_reg == ($past(reg_wdata_in) & osc_pkg::OCP_CFG_MASK))
    else $error("protection register write lost");

  route_write_a: assert property (
    reg_wr_in && hit_route |=> route_reg == ($past(reg_wdata_in) & osc_pkg::LHP_ROUTE_MASK))
    else $error("routing register write lost");

  // Page select write at its offset on any page
  sequence page_write_s;
    reg_wr_in && hit_page;
  endsequence

  page_write_a: assert property (
    page_write_s |=> page_reg == $past(reg_wdata_in))
    else $error("page select not written");

  page_read_a: assert property (
    reg_rd_in && hit_page |=> reg_rdata_out == $past(page_reg))
    else $error("page select read wrong");

  // Reads of the other two config registers return what they store
  cm_read_a: assert property (
    reg_rd_in && hit_cm |=> reg_rdata_out == $past(cm_reg))
    else $error("common mode register read wrong");

  route_read_a: assert property (
    reg_rd_in && hit_route |=> reg_rdata_out == $past(route_reg))
    else $error("routing register read wrong");

  // Off the config page only the page select answers
  off_page_a: assert property (
    reg_rd_in && !on_cfg_page && !hit_page |=> reg_rdata_out == 8'h00)
    else $error("config register read off page");

  // Reserved positions never hold a one, whatever software wrote
  rsvd_store_a: assert property (
    ((cm_reg & ~osc_pkg::CM_CTRL_MASK) == 8'h00)
    && ((ocp_reg & ~osc_pkg::OCP_CFG_MASK) == 8'h00)
    && ((route_reg & ~osc_pkg::LHP_ROUTE_MASK) == 8'h00))
    else $error("reserved bit stored as one");

endmodule // osc_regs

// file: test/test_output_stage_config_regs.sv
// Self-checking bench for the output stage configuration registers.
// Assumes osc_regs with a shortened debounce base and page 1 as config page.
`timescale 1ns/1ns

module test_output_stage_config_regs;
  localparam int DB = 4;  // Short debounce base keeps the run brief
  logic              sys_clk_in      = 1'b0;
  logic              sys_rst_in      = 1'b1;
  logic [7:0]        reg_addr_in     = 8'h00;
  logic [7:0]        reg_wdata_in    = 8'h00;
  logic              reg_wr_in       = 1'b0;
  logic              reg_rd_in       = 1'b0;
  logic [7:0]        reg_rdata_out;
  logic [1:0]        oc_raw_in       = 2'b00;
  osc_pkg::osc_cfg_t cfg_out;
  logic [1:0]        oc_limit_out;
  logic [1:0]        oc_pdn_out;
  int                failures        = 0;
  int                samples_checked = 0;
  // Rows: offset, value written, value read back; writes keep reserved bits at zero
  logic [23:0]       rows [8]        = '{24'h0a_7b7b, 24'h0b_1f1f, 24'h0c_0f0f, 24'h0a_4040,
                                         24'h0b_0000, 24'h0c_0505, 24'h0d_1f00, 24'h00_0101};

  osc_regs #(.NUM_DRV(2), .CNT_W(24), .DEB_BASE(DB)) DUT (
    .sys_clk_in    (sys_clk_in),
    .sys_rst_in    (sys_rst_in),
    .reg_addr_in   (reg_addr_in),
    .reg_wdata_in  (reg_wdata_in),
    .reg_wr_in     (reg_wr_in),
    .reg_rd_in     (reg_rd_in),
    .reg_rdata_out (reg_rdata_out),
    .oc_raw_in     (oc_raw_in),
    .cfg_out       (cfg_out),
    .oc_limit_out  (oc_limit_out),
    .oc_pdn_out    (oc_pdn_out)
  );

  // 25 MHz clock
  always #20 sys_clk_in = ~sys_clk_in;

  // Compare tasks, one per kind of result
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_cfg(input osc_pkg::osc_cfg_t e);
    samples_checked++;
    if (cfg_out !== e) begin
      failures++;
      $display("[ERR] cfg_out expected %h seen %h", e, cfg_out);
    end
  endtask
  task automatic chk_oc(input logic [1:0] el, input logic [1:0] ep);
    samples_checked++;
    if ({oc_limit_out, oc_pdn_out} !== {el, ep}) begin
      failures++;
      $display("[ERR] limit/pdn expected %b seen %b", {el, ep}, {oc_limit_out, oc_pdn_out});
    end
  endtask

  // Bus cycles: one-cycle strobes, read data checked in the following cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    reg_wr_in    <= 1'b1;
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk_in);
    reg_rd_in   <= 1'b1;
    reg_addr_in <= a;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    #1 chk8("read data", e, reg_rdata_out);
  endtask

  // Fault held until the response must appear, checked one edge early too
  task automatic oc(input logic [2:0] code, input logic mode);
    int tgt;
    tgt = (code == 3'd0) ? 0 : DB << (code - 1);
    wr(8'h0b, {3'b000, 1'b1, code, mode});
    repeat (3) @(posedge sys_clk_in);
    oc_raw_in <= 2'b11;
    repeat (tgt) @(posedge sys_clk_in);
    #1 chk_oc(2'b00, 2'b00);
    @(posedge sys_clk_in);
    #1 chk_oc(mode ? 2'b00 : 2'b11, mode ? 2'b11 : 2'b00);
    @(posedge sys_clk_in);
    oc_raw_in <= 2'b00;
    repeat (2) @(posedge sys_clk_in);
    #1 chk_oc(2'b00, 2'b00);
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (6) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    #1 chk_cfg(10'h000);
    chk_oc(2'b00, 2'b00);
    rd(8'h00, 8'h00);
    rd(8'h0a, 8'h00);
    wr(8'h0b, 8'h00);
    wr(8'h00, 8'h01);
    rd(8'h0a, 8'h00);
    rd(8'h0b, 8'h10);
    rd(8'h0c, 8'h00);
    @(posedge sys_clk_in);
    #1 chk8("read idle", 8'h00, reg_rdata_out);
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], rows[i][7:0]);
    end
    #1 chk_cfg(10'h205);
    $display("table test done");
    wr(8'h0a, 8'h33);
    repeat (2) @(posedge sys_clk_in);
    #1 chk_cfg(10'h1b5);
    wr(8'h0a, 8'h31);
    repeat (2) @(posedge sys_clk_in);
    #1 chk_cfg(10'h185);
    wr(8'h0a, 8'h48);
    repeat (2) @(posedge sys_clk_in);
    #1 chk_cfg(10'h245);
    $display("common mode test done");
    for (int c = 0; c < 8; c++) begin
      oc(c[2:0], c[0]);
    end
    // Short drop in mid-count must restart the full wait
    wr(8'h0b, 8'h12);
    repeat (3) @(posedge sys_clk_in);
    oc_raw_in <= 2'b11;
    repeat (3) @(posedge sys_clk_in);
    oc_raw_in <= 2'b00;
    @(posedge sys_clk_in);
    oc_raw_in <= 2'b11;
    repeat (4) @(posedge sys_clk_in);
    #1 chk_oc(2'b00, 2'b00);
    @(posedge sys_clk_in);
    #1 chk_oc(2'b11, 2'b00);
    @(posedge sys_clk_in);
    oc_raw_in <= 2'b00;
    // Detection off: a standing fault gives no response
    wr(8'h0b, 8'h00);
    repeat (3) @(posedge sys_clk_in);
    oc_raw_in <= 2'b11;
    repeat (6) @(posedge sys_clk_in);
    #1 chk_oc(2'b00, 2'b00);
    @(posedge sys_clk_in);
    oc_raw_in <= 2'b00;
    $display("over-current test done");
    // Second reset in mid-run brings the page back to zero
    @(posedge sys_clk_in);
    sys_rst_in <= 1'b1;
    @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    #1 chk_cfg(10'h000);
    rd(8'h00, 8'h00);
    $display("second reset test done");
    results();
  end

  // Watchdog: whole run needs under 5000 cycles
  initial begin
    #200000;
    failures++;
    $display("watchdog expired");
    results();
  end
endmodule // test_output_stage_config_regs
